//--- hw/cttr_top.sv
// Time-of-day and calendar counter registers with oscillator-stopped flag
//
// Summary of operation
// RQ1: Seconds at 03h, BCD tens 6:4, units 3:0
// RQ2: Seconds bit 7 is oscillator-stopped flag, starts set
// RQ3: Flag set on oscillator stop, host clears
// RQ4: Clear attempts ignored while oscillator not running
// RQ5: Power-on sets flag; oscillator stopped until stable
// RQ6: Minutes at 04h, BCD, bit 7 unused
// RQ7: 12-hour: meridiem bit 5, tens bit 4
// RQ8: 24-hour: tens bits 5:4, bits 7:6 unused
// RQ9: Hour format chosen by control select bit
// RQ10: Day at 06h, BCD tens 5:4
// RQ11: February has 29 days when year divisible by four
// RQ12: Weekday at 07h, binary 0 to 6
// RQ13: Weekday 0 Sunday to 6 Saturday, host-definable
// RQ14: Month at 08h, BCD 01 to 12
// RQ15: Year at 09h, two BCD digits
// RQ16: Each 1 Hz tick advances seconds
// RQ17: Counting frozen during access, one tick held
// RQ18: Host finishes access within one second
// RQ19: Counters carry upward; year wraps 99 to 00
// RQ20: Day rolls to 01 after month's last day
// RQ21: 12-hour runs 12,01..11; meridiem toggles 11 to 12
`timescale 1ns/1ps

module cttr_top
(
   input  wire logic                   clock_in,
   input  wire logic                   reset_in,
   input  wire logic                   tick_1hz_in,
   input  wire logic                   osc_running_in,
   input  wire logic                   hour_mode_12_in,
   input  wire logic                   access_active_in,
   input  wire logic                   wr_en_in,
   input  wire logic                   rd_en_in,
   input  wire logic [7:0]             addr_in,
   input  wire logic [7:0]             wr_data_in,
   output logic      [7:0]             rd_data_out,
   output logic                        oscillator_stopped_flag_out,
   output cttr_pkg::cttr_time_type     time_out
);

   cttr_pkg::cttr_time_type time_q;
   cttr_pkg::cttr_time_type time_d;
   logic                    osf_q;
   logic                    osf_d;
   logic                    pend_q;
   logic                    pend_d;
   logic [7:0]              rd_data_q;

   // Address decode
   wire sel_sec  = (addr_in == cttr_pkg::ADDR_SECONDS);
   wire sel_min  = (addr_in == cttr_pkg::ADDR_MINUTES);
   wire sel_hour = (addr_in == cttr_pkg::ADDR_HOURS);
   wire sel_day  = (addr_in == cttr_pkg::ADDR_DAY);
   wire sel_wday = (addr_in == cttr_pkg::ADDR_WEEKDAY);
   wire sel_mon  = (addr_in == cttr_pkg::ADDR_MONTH);
   wire sel_year = (addr_in == cttr_pkg::ADDR_YEAR);

   // A tick during an access is held and applied once the access ends.
   // Only one is held, so a second tick inside one access is lost.
   wire adv = !access_active_in && (tick_1hz_in || pend_q);          // RQ16 RQ17
   assign pend_d = access_active_in ? (pend_q || tick_1hz_in)        // RQ17 RQ18
                                    : (pend_q && tick_1hz_in);

   // Carry chain
   wire [4:0] hour12_low = time_q.hours[cttr_pkg::HOUR12_MSB:0];
   wire       meridiem   = time_q.hours[cttr_pkg::MERIDIEM_BIT];
   wire       hour_end   = hour_mode_12_in                            // RQ9
                           ? (hour12_low == cttr_pkg::HOUR12_ELEVEN) && meridiem
                           : (time_q.hours == cttr_pkg::HOUR24_LAST);
   wire       leap_year  = cttr_pkg::cttr_is_leap(time_q.year);       // RQ11
   wire       month_30   = (time_q.month == cttr_pkg::MONTH_APR) ||
                           (time_q.month == cttr_pkg::MONTH_JUN) ||
                           (time_q.month == cttr_pkg::MONTH_SEP) ||
                           (time_q.month == cttr_pkg::MONTH_NOV);
   wire [5:0] month_len  = (time_q.month == cttr_pkg::MONTH_FEB)      // RQ11 RQ20
                           ? (leap_year ? cttr_pkg::DAYS_29 : cttr_pkg::DAYS_28)
                           : (month_30 ? cttr_pkg::DAYS_30 : cttr_pkg::DAYS_31);

   wire sec_carry  = (time_q.seconds == cttr_pkg::SECONDS_LAST);                   // RQ19
   wire min_carry  = sec_carry && (time_q.minutes == cttr_pkg::MINUTES_LAST);      // RQ19
   wire hour_carry = min_carry && hour_end;                                        // RQ19
   wire day_carry  = hour_carry && (time_q.day == month_len);                      // RQ20
   wire mon_carry  = day_carry && (time_q.month == cttr_pkg::MONTH_LAST);          // RQ19

   // Incremented values
   wire [7:0] sec_inc  = cttr_pkg::cttr_bcd_inc({1'b0, time_q.seconds});
   wire [7:0] min_inc  = cttr_pkg::cttr_bcd_inc({1'b0, time_q.minutes});
   wire [7:0] h24_inc  = cttr_pkg::cttr_bcd_inc({2'b00, time_q.hours});
   wire [7:0] h12_inc  = cttr_pkg::cttr_bcd_inc({3'b000, hour12_low});
   wire [7:0] day_inc  = cttr_pkg::cttr_bcd_inc({2'b00, time_q.day});
   wire [7:0] mon_inc  = cttr_pkg::cttr_bcd_inc({3'b000, time_q.month});
   wire [7:0] year_inc = cttr_pkg::cttr_bcd_inc(time_q.year);

   wire [6:0] sec_next = sec_carry ? 7'h00 : sec_inc[6:0];                         // RQ1
   wire [6:0] min_next = min_carry ? 7'h00 : min_inc[6:0];                         // RQ6
   wire [5:0] h24_next = hour_end ? 6'h00 : h24_inc[5:0];                          // RQ8
   wire [4:0] h12_low_next = (hour12_low == cttr_pkg::HOUR12_TWELVE)               // RQ21
                             ? cttr_pkg::HOUR12_ONE : h12_inc[4:0];
   wire       merid_next   = meridiem ^ (hour12_low == cttr_pkg::HOUR12_ELEVEN);   // RQ21
   wire [5:0] h12_next     = {merid_next, h12_low_next};                           // RQ7
   wire [5:0] hour_next    = hour_mode_12_in ? h12_next : h24_next;                // RQ9
   wire [5:0] day_next     = day_carry ? cttr_pkg::DAY_FIRST : day_inc[5:0];       // RQ10 RQ20
   wire [2:0] wday_next    = (time_q.weekday == cttr_pkg::WEEKDAY_LAST)            // RQ12 RQ13
                             ? 3'h0 : time_q.weekday + 3'h1;
   wire [4:0] mon_next     = mon_carry ? cttr_pkg::MONTH_FIRST : mon_inc[4:0];     // RQ14
   wire [7:0] year_next    = (time_q.year == cttr_pkg::YEAR_LAST)                  // RQ15 RQ19
                             ? 8'h00 : year_inc;

   // Next state: a host write to a register beats the count for that register
   always_comb
   begin
      time_d = time_q;
      if (adv)
      begin
         time_d.seconds = sec_next;                                  // RQ16
         if (sec_carry)
            time_d.minutes = min_next;
         if (min_carry)
            time_d.hours = hour_next;
         if (hour_carry)
         begin
            time_d.day     = day_next;
            time_d.weekday = wday_next;
         end
         if (day_carry)
            time_d.month = mon_next;
         if (mon_carry)
            time_d.year = year_next;
      end
      if (wr_en_in)
      begin
         if (sel_sec)
            time_d.seconds = wr_data_in[cttr_pkg::SECONDS_MSB:0];   // RQ1
         if (sel_min)
            time_d.minutes = wr_data_in[cttr_pkg::MINUTES_MSB:0];   // RQ6
         if (sel_hour)
            time_d.hours = wr_data_in[cttr_pkg::HOURS_MSB:0];       // RQ7 RQ8
         if (sel_day)
            time_d.day = wr_data_in[cttr_pkg::DAY_MSB:0];           // RQ10
         if (sel_wday)
            time_d.weekday = wr_data_in[cttr_pkg::WEEKDAY_MSB:0];   // RQ12
         if (sel_mon)
            time_d.month = wr_data_in[cttr_pkg::MONTH_MSB:0];       // RQ14
         if (sel_year)
            time_d.year = wr_data_in[cttr_pkg::YEAR_MSB:0];         // RQ15
      end
   end

   // Oscillator stop sets the flag and overrides any clearing write
   wire osf_write = wr_en_in && sel_sec;
   assign osf_d = !osc_running_in ||                                 // RQ3 RQ4 RQ5
                  (osf_write ? wr_data_in[cttr_pkg::OSF_BIT] : osf_q);

   // Read mux; unused bits read as zero
   wire [7:0] rd_mux =
      sel_sec  ? {osf_q, time_q.seconds} :                           // RQ2
      sel_min  ? {1'b0, time_q.minutes} :
      sel_hour ? {2'b00, time_q.hours} :
      sel_day  ? {2'b00, time_q.day} :
      sel_wday ? {5'b00000, time_q.weekday} :
      sel_mon  ? {3'b000, time_q.month} :
      sel_year ? time_q.year : cttr_pkg::READ_NONE;

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         time_q    <= cttr_pkg::TIME_RESET;
         osf_q     <= cttr_pkg::OSF_RESET;                           // RQ2 RQ5
         pend_q    <= 1'b0;
         rd_data_q <= cttr_pkg::READ_NONE;
      end
      else
      begin
         time_q <= time_d;
         osf_q  <= osf_d;
         pend_q <= pend_d;
         if (rd_en_in)
            rd_data_q <= rd_mux;
      end
   end

   assign rd_data_out                 = rd_data_q;
   assign oscillator_stopped_flag_out = osf_q;
   assign time_out                    = time_q;

   // Checks
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);

   sequence s_quiet_tick;
      adv && !wr_en_in;
   endsequence

   sequence s_day_step;
      adv && hour_carry && !wr_en_in;
   endsequence

   chk_osf_held_stop: assert property (                               // RQ3 RQ4
      !osc_running_in |=> osf_q [*1])
      else $error("stopped flag not held while oscillator stopped");

   chk_osf_clear_ok: assert property (                                // RQ3
      osc_running_in && osf_write && !wr_data_in[cttr_pkg::OSF_BIT] |=> !osf_q)
      else $error("stopped flag not cleared by write");

   chk_osf_power_on: assert property (                                // RQ5
      $fell(reset_in) |-> osf_q)
      else $error("stopped flag not set after reset");

   chk_freeze_access: assert property (                               // RQ17
      access_active_in && !wr_en_in |=> $stable(time_q))
      else $error("time changed during access");

   chk_pending_apply: assert property (                               // RQ17
      pend_q && !access_active_in && !wr_en_in
      |=> time_q.seconds != $past(time_q.seconds))
      else $error("held tick not applied after access");

   chk_sec_wrap: assert property (                                    // RQ19
      s_quiet_tick and sec_carry |=> time_q.seconds == 7'h00 &&
      time_q.minutes == $past(min_next))
      else $error("seconds did not carry into minutes");

   chk_meridiem_flip: assert property (                               // RQ21
      s_quiet_tick and min_carry && hour_mode_12_in &&
      hour12_low == cttr_pkg::HOUR12_ELEVEN
      |=> time_q.hours[cttr_pkg::MERIDIEM_BIT] != $past(meridiem) &&
          time_q.hours[cttr_pkg::HOUR12_MSB:0] == cttr_pkg::HOUR12_TWELVE)
      else $error("meridiem not toggled at 11 to 12");

   chk_feb_leap: assert property (                                    // RQ11
      s_day_step and time_q.month == cttr_pkg::MONTH_FEB &&
      time_q.day == cttr_pkg::DAYS_28 && leap_year
      |=> time_q.day == cttr_pkg::DAYS_29)
      else $error("leap February lacks day 29");

   chk_day_rollover: assert property (                                // RQ20
      s_day_step and time_q.day == month_len
      |=> time_q.day == cttr_pkg::DAY_FIRST ##0 time_q.month != $past(time_q.month))
      else $error("day did not roll into next month");

   chk_year_wrap: assert property (                                   // RQ19
      s_day_step and mon_carry && time_q.year == cttr_pkg::YEAR_LAST
      |=> time_q.year == 8'h00)
      else $error("year did not wrap to 00");

   chk_wday_range: assert property (                                  // RQ12
      time_q.weekday <= cttr_pkg::WEEKDAY_LAST || $past(wr_en_in))
      else $error("weekday counted past 6");

   sequence s_hour_step;
      adv && min_carry && !wr_en_in;
   endsequence

   sequence s_access_tick;
      access_active_in && tick_1hz_in;
   endsequence

   chk_sec_write: assert property (                                   // RQ1
      wr_en_in && sel_sec
      |=> time_q.seconds == $past(wr_data_in[cttr_pkg::SECONDS_MSB:0]))
      else $error("seconds write not taken");

   chk_min_write: assert property (                                   // RQ6
      wr_en_in && sel_min
      |=> time_q.minutes == $past(wr_data_in[cttr_pkg::MINUTES_MSB:0]))
      else $error("minutes write not taken");

   chk_hour_write: assert property (                                  // RQ7 RQ8
      wr_en_in && sel_hour
      |=> time_q.hours == $past(wr_data_in[cttr_pkg::HOURS_MSB:0]))
      else $error("hours write not taken");

   chk_day_write: assert property (                                   // RQ10
      wr_en_in && sel_day
      |=> time_q.day == $past(wr_data_in[cttr_pkg::DAY_MSB:0]))
      else $error("day write not taken");

   chk_wday_write: assert property (                                  // RQ12
      wr_en_in && sel_wday
      |=> time_q.weekday == $past(wr_data_in[cttr_pkg::WEEKDAY_MSB:0]))
      else $error("weekday write not taken");

   chk_mon_write: assert property (                                   // RQ14
      wr_en_in && sel_mon
      |=> time_q.month == $past(wr_data_in[cttr_pkg::MONTH_MSB:0]))
      else $error("month write not taken");

   chk_year_write: assert property (                                  // RQ15
      wr_en_in && sel_year
      |=> time_q.year == $past(wr_data_in[cttr_pkg::YEAR_MSB:0]))
      else $error("year write not taken");

   chk_read_sec: assert property (                                    // RQ2
      rd_en_in && sel_sec
      |=> rd_data_out == {$past(osf_q), $past(time_q.seconds)})
      else $error("seconds read data wrong");

   chk_h24_wrap: assert property (                                    // RQ8 RQ19
      s_hour_step and !hour_mode_12_in && time_q.hours == cttr_pkg::HOUR24_LAST
      |=> time_q.hours == 6'h00)
      else $error("24-hour count did not wrap");

   chk_h12_one: assert property (                                     // RQ21
      s_hour_step and hour_mode_12_in && hour12_low == cttr_pkg::HOUR12_TWELVE
      |=> time_q.hours == {$past(meridiem), cttr_pkg::HOUR12_ONE})
      else $error("12-hour count did not step 12 to 01");

   chk_h12_day_carry: assert property (                               // RQ19 RQ21
      s_hour_step and hour_mode_12_in && hour_end
      |=> time_q.hours == {1'b0, cttr_pkg::HOUR12_TWELVE})
      else $error("11 PM did not step to 12 AM");

   chk_feb_plain: assert property (                                   // RQ11 RQ20
      s_day_step and time_q.month == cttr_pkg::MONTH_FEB &&
      time_q.day == cttr_pkg::DAYS_28 && !leap_year
      |=> time_q.day == cttr_pkg::DAY_FIRST)
      else $error("common February did not end at 28");

   chk_wday_step: assert property (                                   // RQ12 RQ13
      s_day_step and time_q.weekday == cttr_pkg::WEEKDAY_LAST
      |=> time_q.weekday == 3'h0)
      else $error("weekday did not wrap to 0");

   chk_month_wrap: assert property (                                  // RQ14 RQ19
      s_day_step and mon_carry
      |=> time_q.month == cttr_pkg::MONTH_FIRST)
      else $error("month did not wrap to 01");

   chk_tick_advance: assert property (                                // RQ16
      s_quiet_tick
      |=> time_q.seconds != $past(time_q.seconds))
      else $error("tick did not advance seconds");

   chk_idle_stable: assert property (                                 // RQ16 RQ17
      !adv && !wr_en_in
      |=> $stable(time_q))
      else $error("time changed without tick or write");

   chk_pend_hold: assert property (                                   // RQ17
      s_access_tick
      |=> pend_q)
      else $error("tick during access not held");

endmodule // cttr_top

//--- hw/cttr_pkg.sv
// Constants, field layouts and helpers for the calendar time registers
package cttr_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_SECONDS = 8'h03;
   localparam logic [7:0] ADDR_MINUTES = 8'h04;
   localparam logic [7:0] ADDR_HOURS   = 8'h05;
   localparam logic [7:0] ADDR_DAY     = 8'h06;
   localparam logic [7:0] ADDR_WEEKDAY = 8'h07;
   localparam logic [7:0] ADDR_MONTH   = 8'h08;
   localparam logic [7:0] ADDR_YEAR    = 8'h09;

   // Field positions
   localparam int OSF_BIT       = 7;
   localparam int MERIDIEM_BIT  = 5;
   localparam int SECONDS_MSB   = 6;
   localparam int MINUTES_MSB   = 6;
   localparam int HOURS_MSB     = 5;
   localparam int HOUR12_MSB    = 4;
   localparam int DAY_MSB       = 5;
   localparam int WEEKDAY_MSB   = 2;
   localparam int MONTH_MSB     = 4;
   localparam int YEAR_MSB      = 7;

   // Counting limits, all BCD except the weekday
   localparam logic [6:0] SECONDS_LAST = 7'h59;
   localparam logic [6:0] MINUTES_LAST = 7'h59;
   localparam logic [5:0] HOUR24_LAST  = 6'h23;
   localparam logic [4:0] HOUR12_ELEVEN = 5'h11;
   localparam logic [4:0] HOUR12_TWELVE = 5'h12;
   localparam logic [4:0] HOUR12_ONE    = 5'h01;
   localparam logic [2:0] WEEKDAY_LAST = 3'h6;
   localparam logic [5:0] DAY_FIRST    = 6'h01;
   localparam logic [5:0] DAYS_28      = 6'h28;
   localparam logic [5:0] DAYS_29      = 6'h29;
   localparam logic [5:0] DAYS_30      = 6'h30;
   localparam logic [5:0] DAYS_31      = 6'h31;
   localparam logic [4:0] MONTH_FIRST  = 5'h01;
   localparam logic [4:0] MONTH_LAST   = 5'h12;
   localparam logic [4:0] MONTH_FEB    = 5'h02;
   localparam logic [4:0] MONTH_APR    = 5'h04;
   localparam logic [4:0] MONTH_JUN    = 5'h06;
   localparam logic [4:0] MONTH_SEP    = 5'h09;
   localparam logic [4:0] MONTH_NOV    = 5'h11;
   localparam logic [7:0] YEAR_LAST    = 8'h99;
   localparam logic [3:0] BCD_NINE     = 4'h9;
   localparam logic [3:0] BCD_ONE      = 4'h1;

   // Counting rate of the tick input
   localparam int TICK_RATE_HZ = 1;

   typedef struct packed {
      logic [6:0] seconds;
      logic [6:0] minutes;
      logic [5:0] hours;
      logic [5:0] day;
      logic [2:0] weekday;
      logic [4:0] month;
      logic [7:0] year;
   } cttr_time_type;

   // Power-on calendar value: 00:00:00, day 01, month 01, year 00, weekday 0
   localparam cttr_time_type TIME_RESET = '{
      seconds: 7'h00, minutes: 7'h00, hours: 6'h00, day: 6'h01,
      weekday: 3'h0, month: 5'h01, year: 8'h00};
   localparam logic OSF_RESET = 1'b1;
   localparam logic [7:0] READ_NONE = 8'h00;

   function automatic logic [7:0] cttr_bcd_inc(input logic [7:0] v);
      if (v[3:0] == BCD_NINE)
         cttr_bcd_inc = {v[7:4] + BCD_ONE, 4'h0};
      else
         cttr_bcd_inc = {v[7:4], v[3:0] + BCD_ONE};
   endfunction

   // BCD year divisible by four: even tens with units 0/4/8, odd tens with 2/6
   function automatic logic cttr_is_leap(input logic [7:0] y);
      if (y[4] == 1'b0)
         cttr_is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      else
         cttr_is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
   endfunction

endpackage

//--- testbench/cttr_host_model.sv
// Host-side model of the register port behind the serial interface
`timescale 1ns/1ps

module cttr_host_model
(
   input  wire logic       clock_in,
   input  wire logic [7:0] rd_data_in,
   output logic            access_active_out,
   output logic            wr_en_out,
   output logic            rd_en_out,
   output logic [7:0]      addr_out,
   output logic [7:0]      wr_data_out
);
   initial
   begin
      access_active_out = 1'h0;
      wr_en_out = 1'h0;
      rd_en_out = 1'h0;
      addr_out = 8'h00;
      wr_data_out = 8'h00;
   end

   // All bytes go in one access so no carry can land between them
   task automatic open_access();
      @(posedge clock_in);
      #1 access_active_out = 1'h1;
   endtask

   task automatic close_access();
      @(posedge clock_in);
      #1 access_active_out = 1'h0;
   endtask

   // Released lines show the inverse so a stale value never looks valid
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      #1;
      wr_en_out = 1'h1;
      addr_out = a;
      wr_data_out = d;
      @(posedge clock_in);
      #1;
      wr_en_out = 1'h0;
      addr_out = ~a;
      wr_data_out = ~d;
   endtask

   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_in);
      #1;
      rd_en_out = 1'h1;
      addr_out = a;
      @(posedge clock_in);
      #1;
      rd_en_out = 1'h0;
      addr_out = ~a;
      d = rd_data_in;
   endtask
endmodule // cttr_host_model

//--- testbench/testbench.sv
// Self-checking bench for the calendar time registers
`timescale 1ns/1ps

module testbench;
   typedef cttr_pkg::cttr_time_type cttr_tv_type;
   logic       clock_in = 1'h0;
   logic       reset_in = 1'h1;
   logic       tick = 1'h0;
   logic       osc_run = 1'h0;
   logic       mode12 = 1'h0;
   logic       acc, wr_en, rd_en, osf;
   logic [7:0] addr, wdata, rdata, r;
   cttr_tv_type tout, t;
   int         fail_count = 0;
   int         n_checks = 0;
   localparam cttr_tv_type CORNERS [11] = '{
      '{7'h59, 7'h59, 6'h23, 6'h31, 3'h6, 5'h12, 8'h99},
      '{7'h59, 7'h59, 6'h23, 6'h28, 3'h1, 5'h02, 8'h01},
      '{7'h59, 7'h59, 6'h23, 6'h28, 3'h2, 5'h02, 8'h04},
      '{7'h59, 7'h59, 6'h23, 6'h29, 3'h3, 5'h02, 8'h00},
      '{7'h59, 7'h59, 6'h23, 6'h28, 3'h4, 5'h02, 8'h00},
      '{7'h59, 7'h59, 6'h23, 6'h30, 3'h5, 5'h04, 8'h10},
      '{7'h59, 7'h59, 6'h23, 6'h31, 3'h0, 5'h01, 8'h37},
      '{7'h59, 7'h59, 6'h11, 6'h05, 3'h1, 5'h07, 8'h20},
      '{7'h59, 7'h59, 6'h31, 6'h31, 3'h6, 5'h12, 8'h99},
      '{7'h59, 7'h59, 6'h12, 6'h30, 3'h2, 5'h11, 8'h12},
      '{7'h59, 7'h59, 6'h32, 6'h15, 3'h3, 5'h09, 8'h45}};

   always #12.5 clock_in = ~clock_in;

   cttr_top u_dut (.clock_in(clock_in), .reset_in(reset_in), .tick_1hz_in(tick),
      .osc_running_in(osc_run), .hour_mode_12_in(mode12), .access_active_in(acc),
      .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr), .wr_data_in(wdata),
      .rd_data_out(rdata), .oscillator_stopped_flag_out(osf), .time_out(tout));
   cttr_host_model u_host (.clock_in(clock_in), .rd_data_in(rdata), .access_active_out(acc),
      .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr), .wr_data_out(wdata));

   task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
      n_checks++;
      if (seen !== want)
      begin
         fail_count++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, want);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   function automatic int b2i(input logic [7:0] v);
      return v[7:4] * 10 + v[3:0];
   endfunction

   function automatic logic [7:0] i2b(input int v);
      return 8'((v / 10) * 16 + v % 10);
   endfunction

   // Decimal reference of one advance; 12-hour runs 12,1..11 with the day carry at 12 AM
   function automatic cttr_tv_type next_time(input cttr_tv_type t, input logic m12);
      int s, mi, h, d, mo, y, dm;
      logic pm, cy;
      s = b2i({1'h0, t.seconds}) + 1;
      mi = b2i({1'h0, t.minutes});
      h = m12 ? b2i({3'h0, t.hours[4:0]}) : b2i({2'h0, t.hours});
      pm = m12 & t.hours[5];
      d = b2i({2'h0, t.day});
      mo = b2i({3'h0, t.month});
      y = b2i(t.year);
      cy = 1'h0;
      if (s == 60)
      begin
         s = 0;
         mi++;
      end
      if (mi == 60)
      begin
         mi = 0;
         if (!m12)
         begin
            h = (h + 1) % 24;
            cy = (h == 0);
         end
         else if (h == 12)
            h = 1;
         else
         begin
            h++;
            if (h == 12)
            begin
               pm = ~pm;
               cy = ~pm;
            end
         end
      end
      if (cy)
      begin
         dm = (mo == 2) ? ((y % 4 == 0) ? 29 : 28)
            : (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
         t.weekday = (t.weekday == 3'h6) ? 3'h0 : t.weekday + 3'h1;
         d++;
         if (d > dm)
         begin
            d = 1;
            mo++;
         end
         if (mo == 13)
         begin
            mo = 1;
            y = (y + 1) % 100;
         end
      end
      t.seconds = 7'(i2b(s));
      t.minutes = 7'(i2b(mi));
      t.hours = m12 ? {pm, 5'(i2b(h))} : 6'(i2b(h));
      t.day = 6'(i2b(d));
      t.month = 5'(i2b(mo));
      t.year = i2b(y);
      return t;
   endfunction

   function automatic logic [7:0] reg_byte(input cttr_tv_type t, input int i);
      case (i)
         0: return {1'h0, t.seconds};
         1: return {1'h0, t.minutes};
         2: return {2'h0, t.hours};
         3: return {2'h0, t.day};
         4: return {5'h00, t.weekday};
         5: return {3'h0, t.month};
         default: return t.year;
      endcase
   endfunction

   function automatic cttr_tv_type rand_time();
      cttr_tv_type v;
      v.seconds = 7'(i2b($urandom_range(59, 50)));
      v.minutes = $urandom_range(1) ? 7'h59 : 7'(i2b($urandom_range(59)));
      v.hours = mode12 ? {1'($urandom_range(1)), 5'(i2b($urandom_range(12, 1)))}
                       : 6'(i2b($urandom_range(23)));
      v.day = 6'(i2b($urandom_range(28, 1)));
      v.weekday = 3'($urandom_range(6));
      v.month = 5'(i2b($urandom_range(12, 1)));
      v.year = i2b($urandom_range(99));
      return v;
   endfunction

   task automatic set_time(input cttr_tv_type v);
      u_host.open_access();
      for (int i = 0; i < 7; i++)
         u_host.write_reg(8'(3 + i), reg_byte(v, i));
      for (int i = 0; i < 7; i++)
      begin
         u_host.read_reg(8'(3 + i), r);
         check(64'(r), 64'(reg_byte(v, i)), "read");
      end
      u_host.close_access();
   endtask

   task automatic pulse_tick();
      @(posedge clock_in);
      #1 tick = 1'h1;
      @(posedge clock_in);
      #1 tick = 1'h0;
   endtask

   task automatic advance_check(input cttr_tv_type v);
      pulse_tick();
      @(posedge clock_in);
      #1 check(64'(tout), 64'(next_time(v, mode12)), "advance");
   endtask

   initial
   begin
      void'($urandom(32'hEDB904AB));
      repeat (20) @(posedge clock_in);
      #1 reset_in = 1'h0;
      @(posedge clock_in);
      #1 check(64'(tout), 64'(cttr_pkg::TIME_RESET), "reset time");
      check(64'(osf), 64'h1, "flag at power-on");
      u_host.write_reg(8'h03, 8'h25);
      check(64'(osf), 64'h1, "clear while stopped");
      check(64'(tout.seconds), 64'h25, "seconds write");
      osc_run = 1'h1;
      u_host.write_reg(8'h03, 8'h00);
      check(64'(osf), 64'h0, "clear while running");
      osc_run = 1'h0;
      repeat (3) @(posedge clock_in);
      #1 osc_run = 1'h1;
      repeat (3) @(posedge clock_in);
      #1 check(64'(osf), 64'h1, "flag held after stop");
      u_host.read_reg(8'h03, r);
      check(64'(r), 64'h80, "flag in bit 7");
      u_host.read_reg(8'h0A, r);
      check(64'(r), 64'h00, "unmapped read");
      for (int i = 0; i < 11; i++)
      begin
         mode12 = (i >= 7);
         set_time(CORNERS[i]);
         advance_check(CORNERS[i]);
      end
      for (int i = 0; i < 40; i++)
      begin
         mode12 = 1'($urandom_range(1));
         t = rand_time();
         set_time(t);
         advance_check(t);
      end
      // Two ticks during one access: only one may survive
      t = rand_time();
      set_time(t);
      u_host.open_access();
      pulse_tick();
      pulse_tick();
      check(64'(tout), 64'(t), "frozen during access");
      u_host.close_access();
      repeat (3) @(posedge clock_in);
      #1 check(64'(tout), 64'(next_time(t, mode12)), "one held tick");
      stop_test();
   end

   initial
   begin
      #2000000;
      fail_count++;
      stop_test();
   end
endmodule // testbench
